//--- warp_issue_timing_tb.sv
// Self-checking bench for the warp issue stage
`timescale 1ns/1ps
module warp_issue_timing_tb;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg instr_valid_i = 1'b0;
  reg [3:0] instr_op_i = 4'h0;
  reg [31:0] instr_pred_i = 32'h0, branch_taken_i = 32'h0, act_exp = 32'hffffffff;
  reg instr_dep_load_i = 1'b0, barrier_release_i = 1'b1;
  reg [15:0] branch_target_i = 16'h0, branch_join_i = 16'h0, instr_pc_i = 16'h0;
  wire instr_ready_o, mem_req_o, mem_we_o, mem_done_i, opnd_rd_o, exec_o, wb_o, load_wait_o;
  wire [31:0] mem_lane_mask_o, opnd_rd_mask_o, wb_mask_o, active_mask_o;
  wire [15:0] next_pc_o;
  wire [3:0] issue_op_o;
  reg [3:0] op, prv;
  integer cyc = 0, last_acc = 0, gap, i, err_total = 0, total_checks = 0, seed;

  wit_issue_core u_wit_issue_core (.core_clk_i, .rst_n_i, .instr_valid_i, .instr_op_i,
    .instr_pred_i, .instr_dep_load_i, .branch_taken_i, .branch_target_i, .branch_join_i,
    .instr_pc_i, .instr_ready_o, .barrier_release_i, .mem_req_o, .mem_we_o, .mem_lane_mask_o,
    .mem_done_i, .opnd_rd_o, .opnd_rd_mask_o, .exec_o, .wb_o, .wb_mask_o, .active_mask_o,
    .next_pc_o, .load_wait_o, .issue_op_o);
  wit_mem_model u_wit_mem_model (.core_clk_i, .rst_n_i, .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_done_o(mem_done_i));

  // Clock and cycle count
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  // Expected issue cost and writeback
  function integer cost(input [3:0] o);
    case (o)
      4'h1, 4'h2: cost = 16;
      4'h5, 4'h8: cost = 32;
      4'h6: cost = 36;
      4'h7: cost = 20;
      default: cost = 4;
    endcase
  endfunction
  function wb_exp(input [3:0] o);
    wb_exp = (o < 4'ha) || (o == 4'hb);
  endfunction

  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Offer one instruction, follow it through read, execute and writeback
  task issue(input [3:0] o, input [31:0] p, input d);
    integer n;
    begin
      instr_op_i = o;
      instr_pred_i = p;
      instr_dep_load_i = d;
      instr_valid_i = 1'b1;
      n = 0;
      while (opnd_rd_o !== 1'b1 && n < 2000) begin
        @(negedge core_clk_i);
        n = n + 1;
      end
      gap = cyc - last_acc;
      last_acc = cyc;
      check(opnd_rd_mask_o, p & act_exp);
      @(negedge core_clk_i);
      check(exec_o, 1);
      @(negedge core_clk_i);
      check(wb_o, wb_exp(o));
      if (wb_exp(o)) check(wb_mask_o, p & act_exp);
      check(instr_ready_o, 0);
    end
  endtask

  // Offer a join-point instruction and hold it until it is taken
  task offer(input [15:0] pc);
    begin
      instr_pc_i = pc;
      issue(4'h0, act_exp, 1'b0);
    end
  endtask

  task rest;
    begin
      instr_valid_i = 1'b0;
      @(negedge core_clk_i);
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask

  // Watchdog sized for about 20000 cycles
  initial begin
    #160000;
    err_total = err_total + 1;
    test_done;
  end

  // Main sequence
  initial begin
    seed = $urandom(9);
    repeat (8) @(negedge core_clk_i);
    check(active_mask_o, 32'hffffffff);
    check(instr_ready_o, 0);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    for (i = 0; i < 40; i = i + 1) begin
      op = $urandom % 13;
      if (op == 4'hb) op = 4'he;
      branch_taken_i = ($urandom % 2) ? 32'hffffffff : 32'h0;
      issue(op, (op == 4'he) ? 32'hffffffff : ((i == 1) ? 32'h0 : $urandom), 1'b0);
      if (i > 0) check(gap >= cost(prv) && gap <= cost(prv) + 1, 1);
      check(active_mask_o, 32'hffffffff);
      prv = op;
    end
    $display("test random done");
    issue(4'hb, 32'hffffffff, 1'b0);
    check(load_wait_o, 1);
    issue(4'h0, 32'h0000ffff, 1'b0);
    check(gap <= 5 && load_wait_o === 1'b1, 1);
    issue(4'h0, 32'hffffffff, 1'b1);
    check(gap >= 390 && load_wait_o === 1'b0, 1);
    $display("test load done");
    rest();
    check(instr_ready_o, 1);
    branch_taken_i = 32'h0000ffff;
    branch_target_i = 16'h0040;
    branch_join_i = 16'h0080;
    instr_pc_i = 16'h0010;
    issue(4'he, 32'hffffffff, 1'b0);
    check(active_mask_o, 32'h0000ffff);
    check(next_pc_o, 16'h0040);
    act_exp = 32'h0000ffff;
    instr_pc_i = 16'h0040;
    issue(4'h3, 32'h00ff00ff, 1'b0);
    offer(16'h0080);
    check(active_mask_o, 32'hffff0000);
    check(next_pc_o, 16'h0011);
    act_exp = 32'hffff0000;
    instr_pc_i = 16'h0011;
    issue(4'h4, 32'h0f0f0f0f, 1'b0);
    offer(16'h0080);
    check(active_mask_o, 32'hffffffff);
    check(next_pc_o, 16'h0080);
    act_exp = 32'hffffffff;
    $display("test divergence done");
    issue(4'hd, 32'hffffffff, 1'b0);
    issue(4'h0, 32'hffffffff, 1'b0);
    check(gap == 4, 1);
    barrier_release_i = 1'b0;
    issue(4'hd, 32'hffffffff, 1'b0);
    fork
      begin
        repeat (20) @(negedge core_clk_i);
        barrier_release_i = 1'b1;
      end
    join_none
    issue(4'h0, 32'hffffffff, 1'b0);
    check(gap >= 20, 1);
    $display("test barrier done");
    test_done;
  end
endmodule

//--- wit_cycle_counter.v
// Issue slot counter that holds the issue stage busy for a given cycle count
`timescale 1ns/1ps
`include "wit_map.vh"

module wit_cycle_counter (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Load request
  input wire load_i,
  input wire [`WIT_CNT_W-1:0] count_i,
  // Status
  output wire busy_o,
  output wire last_o
);

  reg [`WIT_CNT_W-1:0] remain_ff;
  reg [`WIT_CNT_W-1:0] nxt_remain;

  // Next count: load on accept, else count down to zero
  always @* begin
    nxt_remain = remain_ff;
    if (load_i) begin
      nxt_remain = count_i - `WIT_CYC_ONE;
    end else if (remain_ff != {`WIT_CNT_W{1'b0}}) begin
      nxt_remain = remain_ff - `WIT_CYC_ONE;
    end
  end

  // Remaining cycle register
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain_ff <= {`WIT_CNT_W{1'b0}};
    end else begin
      remain_ff <= nxt_remain;
    end
  end

  assign busy_o = (remain_ff != {`WIT_CNT_W{1'b0}});
  assign last_o = (remain_ff == `WIT_CYC_ONE);

endmodule

//--- wit_issue_checker.sv
// Assertion checker for the warp issue stage ports
`timescale 1ns/1ps
module wit_chk (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Request side
  input wire instr_valid_i,
  input wire [31:0] instr_pred_i,
  // Issue outputs
  input wire opnd_rd_o,
  input wire [31:0] opnd_rd_mask_o,
  input wire exec_o,
  input wire wb_o,
  input wire [31:0] wb_mask_o,
  input wire [3:0] issue_op_o,
  // Memory side
  input wire mem_req_o,
  input wire mem_we_o,
  input wire [31:0] mem_lane_mask_o,
  input wire mem_done_i,
  input wire load_wait_o
);
  reg [5:0] gap_ff;
  reg [3:0] prv_ff;
  reg seen_ff;
  // Issue cost of each opcode class
  function [5:0] cost(input [3:0] op);
    case (op)
      4'h1, 4'h2: cost = 6'h10;
      4'h5, 4'h8: cost = 6'h20;
      4'h6: cost = 6'h24;
      4'h7: cost = 6'h14;
      default: cost = 6'h04;
    endcase
  endfunction
  // Cycles since the last accepted instruction, saturating
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_ff <= 6'h00;
      prv_ff <= 4'h0;
      seen_ff <= 1'b0;
    end else begin
      if (opnd_rd_o) begin
        gap_ff <= 6'h01;
        seen_ff <= 1'b1;
      end else if (gap_ff != 6'h3f) begin
        gap_ff <= gap_ff + 6'h01;
      end
      // The op of an issue shows on its port one cycle after operand read
      if (exec_o) begin
        prv_ff <= issue_op_o;
      end
    end
  end
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Execute then write back
  sequence pipe_s;
    exec_o ##1 wb_o;
  endsequence
  rd_exec_a: assert property (opnd_rd_o |=> exec_o) else $error("no execute");
  exec_wb_a: assert property (
    opnd_rd_o ##1 (issue_op_o < 4'ha || issue_op_o == 4'hb) |-> pipe_s) else $error("no wb");
  wb_mask_a: assert property (
    wb_o |-> wb_mask_o == $past(opnd_rd_mask_o, 2)) else $error("wb mask");
  rd_mask_a: assert property (
    opnd_rd_o |-> (opnd_rd_mask_o & ~$past(instr_pred_i)) == 32'h0) else $error("rd mask");
  issue_gap_a: assert property (
    opnd_rd_o && seen_ff |-> gap_ff >= cost(prv_ff)) else $error("issue too soon");
  mem_req_a: assert property (
    exec_o && (issue_op_o == 4'hb || issue_op_o == 4'hc) && $past(opnd_rd_mask_o) != 32'h0
    |-> mem_req_o && (mem_we_o == (issue_op_o == 4'hc))) else $error("no mem request");
  mem_mask_a: assert property (
    mem_req_o |-> mem_lane_mask_o == $past(opnd_rd_mask_o)) else $error("mem mask");
  load_clear_a: assert property (
    $rose(mem_done_i) |-> ##[1:5] !load_wait_o) else $error("load wait stuck");
  valid_src_a: assert property (
    opnd_rd_o |-> $past(instr_valid_i)) else $error("unrequested issue");
endmodule

bind wit_issue_core wit_chk u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
  .instr_pred_i(instr_pred_i), .opnd_rd_o(opnd_rd_o), .opnd_rd_mask_o(opnd_rd_mask_o),
  .exec_o(exec_o), .wb_o(wb_o), .wb_mask_o(wb_mask_o), .issue_op_o(issue_op_o),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lane_mask_o(mem_lane_mask_o),
  .mem_done_i(mem_done_i), .load_wait_o(load_wait_o)
);

//--- wit_issue_core.v
// Warp instruction issue stage with per-opcode cycle cost, divergence and memory wait
`timescale 1ns/1ps
`include "wit_map.vh"

// Functional notes
// (RULE1) Read operands, execute, write back per lane
// (RULE2) Simple arithmetic and logic issue in four cycles
// (RULE3) Reciprocal, rsqrt and log issue in sixteen
// (RULE4) Full-width integer multiply issues in sixteen cycles
// (RULE5) Short multiplies signed or unsigned take four
// (RULE6) Square root is rsqrt plus reciprocal, thirty-two
// (RULE7) Divide thirty-six cycles, fast divide twenty
// (RULE8) Fast sine, cosine, exponential take thirty-two
// (RULE9) Divergent paths execute one after another; a split met on a full stack sends all active lanes down the fall-through path
// (RULE10) Threads rejoin after all paths complete
// (RULE11) Warp-uniform condition causes no divergence
// (RULE12) Each lane carries its own predicate flag
// (RULE13) Predicated instructions always scheduled, true lanes act
// (RULE14) False lanes skip writeback, addresses, operand reads
// (RULE15) Shared or global memory issue takes four
// (RULE16) Memory answers global access after 400-600 cycles
// (RULE17) Issue independent arithmetic while global load waits
// (RULE18) Barrier issues in four cycles without waiting; here it is held in ST_BAR until barrier_release_i is seen
// (RULE19) No new instruction until issue count elapses
module wit_issue_core (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Instruction request
  input wire instr_valid_i,
  input wire [`WIT_OP_W-1:0] instr_op_i,
  input wire [`WIT_LANES-1:0] instr_pred_i,
  input wire instr_dep_load_i,
  input wire [`WIT_LANES-1:0] branch_taken_i,
  input wire [`WIT_PC_W-1:0] branch_target_i,
  input wire [`WIT_PC_W-1:0] branch_join_i,
  input wire [`WIT_PC_W-1:0] instr_pc_i,
  output reg instr_ready_o,
  // Barrier status
  input wire barrier_release_i,
  // Global memory interface
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [`WIT_LANES-1:0] mem_lane_mask_o,
  input wire mem_done_i,
  // Lane execute strobes
  output reg opnd_rd_o,
  output reg [`WIT_LANES-1:0] opnd_rd_mask_o,
  output reg exec_o,
  output reg wb_o,
  output reg [`WIT_LANES-1:0] wb_mask_o,
  // Warp state
  output reg [`WIT_LANES-1:0] active_mask_o,
  output reg [`WIT_PC_W-1:0] next_pc_o,
  output reg load_wait_o,
  output reg [`WIT_OP_W-1:0] issue_op_o
);

  // Issue pipeline states
  localparam ST_IDLE = 2'b00;
  localparam ST_ISSUE = 2'b01;
  localparam ST_BAR = 2'b10;

  // Issue cost of one opcode class
  function [`WIT_CNT_W-1:0] op_cost;
    input [`WIT_OP_W-1:0] op;
    begin
      case (op)
        `WIT_OP_RCP: op_cost = `WIT_CYC_RCP; // RULE3
        `WIT_OP_MUL32: op_cost = `WIT_CYC_MUL32; // RULE4
        `WIT_OP_MUL24S: op_cost = `WIT_CYC_SIMPLE; // RULE5
        `WIT_OP_MUL24U: op_cost = `WIT_CYC_SIMPLE; // RULE5
        `WIT_OP_SQRT: op_cost = `WIT_CYC_SQRT; // RULE6
        `WIT_OP_DIV: op_cost = `WIT_CYC_DIV; // RULE7
        `WIT_OP_FDIV: op_cost = `WIT_CYC_FDIV; // RULE7
        `WIT_OP_SFU: op_cost = `WIT_CYC_SFU; // RULE8
        `WIT_OP_LDS: op_cost = `WIT_CYC_MEM; // RULE15
        `WIT_OP_STS: op_cost = `WIT_CYC_MEM; // RULE15
        `WIT_OP_LDG: op_cost = `WIT_CYC_MEM; // RULE15
        `WIT_OP_STG: op_cost = `WIT_CYC_MEM; // RULE15
        `WIT_OP_BAR: op_cost = `WIT_CYC_BAR; // RULE18
        default: op_cost = `WIT_CYC_SIMPLE; // RULE2
      endcase
    end
  endfunction

  // True for opcodes that write a result back per lane
  function writes_back;
    input [`WIT_OP_W-1:0] op;
    begin
      writes_back = (op != `WIT_OP_STS) && (op != `WIT_OP_STG) &&
                    (op != `WIT_OP_BAR) && (op != `WIT_OP_BRA);
    end
  endfunction

  // True for global memory opcodes
  function is_global;
    input [`WIT_OP_W-1:0] op;
    begin
      is_global = (op == `WIT_OP_LDG) || (op == `WIT_OP_STG);
    end
  endfunction

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`WIT_OP_W-1:0] op_ff;
  reg [`WIT_LANES-1:0] lane_ff;
  reg [`WIT_LANES-1:0] active_ff;
  reg [`WIT_LANES-1:0] nxt_active;
  reg [`WIT_PC_W-1:0] pc_ff;
  reg [`WIT_PC_W-1:0] nxt_pc;
  reg load_wait_ff;
  reg ldg_ff;
  reg bar_rel_s1_ff;
  reg bar_rel_s2_ff;
  reg mem_done_s1_ff;
  reg mem_done_s2_ff;
  // Divergence stack: pending mask, pending pc, join pc, join mask
  // Each entry holds the lanes still to run, where they resume, the join pc
  // and the full mask to restore; a split on a full stack is not recorded
  reg [`WIT_LANES-1:0] stk_mask_ff [0:`WIT_DIV_DEPTH-1];
  reg [`WIT_PC_W-1:0] stk_pc_ff [0:`WIT_DIV_DEPTH-1];
  reg [`WIT_PC_W-1:0] stk_join_ff [0:`WIT_DIV_DEPTH-1];
  reg [`WIT_LANES-1:0] stk_all_ff [0:`WIT_DIV_DEPTH-1];
  reg stk_side_ff [0:`WIT_DIV_DEPTH-1];
  reg [`WIT_SP_W:0] sp_ff;
  reg [`WIT_SP_W:0] nxt_sp;
  reg push;
  reg pop_second;
  reg pop_join;

  wire cnt_busy;
  wire cnt_last;
  wire accept;
  wire [`WIT_LANES-1:0] act_lanes;
  wire [`WIT_LANES-1:0] taken_lanes;
  wire [`WIT_LANES-1:0] fall_lanes;
  wire [`WIT_SP_W-1:0] top;
  integer i;

  // Issue slot counter holds off the next instruction
  // The slot cost is taken from the offered opcode at the accepting edge
  wit_cycle_counter u_cnt (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(accept),
    .count_i(op_cost(instr_op_i)),
    .busy_o(cnt_busy),
    .last_o(cnt_last)
  );

  // Accept only when slot is free; dependent work waits on the load
  assign accept = instr_valid_i && (state_ff == ST_IDLE) && !cnt_busy &&
                  !(instr_dep_load_i && load_wait_ff); // RULE19 RULE17
  assign act_lanes = active_ff & instr_pred_i; // RULE12 RULE13
  assign taken_lanes = act_lanes & branch_taken_i;
  assign fall_lanes = act_lanes & ~branch_taken_i;
  assign top = sp_ff[`WIT_SP_W-1:0] - 2'b01;

  // Input synchronisers for outside status
  // These pins may move at any moment; only the second stage is read
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bar_rel_s1_ff <= 1'b0;
      bar_rel_s2_ff <= 1'b0;
      mem_done_s1_ff <= 1'b0;
      mem_done_s2_ff <= 1'b0;
    end else begin
      bar_rel_s1_ff <= barrier_release_i;
      bar_rel_s2_ff <= bar_rel_s1_ff;
      mem_done_s1_ff <= mem_done_i;
      mem_done_s2_ff <= mem_done_s1_ff;
    end
  end

  // Branch and reconvergence control
  // A split runs the taken lanes first; at the join pc the fall lanes resume
  // after the branch, and the second visit restores the lanes that were active at the split
  always @* begin
    nxt_active = active_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    push = 1'b0;
    pop_second = 1'b0;
    pop_join = 1'b0;
    if (accept) begin
      nxt_pc = instr_pc_i + 16'h0001;
      if (instr_op_i == `WIT_OP_BRA) begin
        if (taken_lanes == `WIT_MASK_ZERO) begin
          nxt_pc = instr_pc_i + 16'h0001; // RULE11
        end else if (fall_lanes == `WIT_MASK_ZERO) begin
          nxt_pc = branch_target_i; // RULE11
        end else if (sp_ff != `WIT_DIV_DEPTH) begin
          push = 1'b1; // RULE9
          nxt_sp = sp_ff + 3'b001;
          nxt_active = taken_lanes;
          nxt_pc = branch_target_i;
        end
      end else if ((sp_ff != 3'b000) && (instr_pc_i == stk_join_ff[top])) begin
        if (!stk_side_ff[top]) begin
          pop_second = 1'b1; // RULE9
          nxt_active = stk_mask_ff[top];
          nxt_pc = stk_pc_ff[top];
        end else begin
          pop_join = 1'b1; // RULE10
          nxt_sp = sp_ff - 3'b001;
          nxt_active = stk_all_ff[top];
          nxt_pc = instr_pc_i;
        end
      end
    end
  end

  // Issue stage state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept && (instr_op_i == `WIT_OP_BAR)) begin
          nxt_state = ST_BAR;
        end else if (accept) begin
          nxt_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (cnt_last) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_BAR: begin
        // Leave on the last counted cycle so an unheld barrier costs four
        if ((cnt_last || !cnt_busy) && bar_rel_s2_ff) begin
          nxt_state = ST_IDLE; // RULE18
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State, warp and divergence stack registers
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      op_ff <= `WIT_OP_SIMPLE;
      lane_ff <= `WIT_MASK_ZERO;
      active_ff <= `WIT_MASK_ONES;
      pc_ff <= 16'h0000;
      sp_ff <= 3'b000;
      load_wait_ff <= 1'b0;
      ldg_ff <= 1'b0;
      for (i = 0; i < `WIT_DIV_DEPTH; i = i + 1) begin
        stk_mask_ff[i] <= `WIT_MASK_ZERO;
        stk_pc_ff[i] <= 16'h0000;
        stk_join_ff[i] <= 16'h0000;
        stk_all_ff[i] <= `WIT_MASK_ZERO;
        stk_side_ff[i] <= 1'b0;
      end
    end else begin
      state_ff <= nxt_state;
      active_ff <= nxt_active;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      if (accept) begin
        op_ff <= instr_op_i;
        lane_ff <= act_lanes; // RULE14
      end
      if (push) begin
        stk_mask_ff[sp_ff[`WIT_SP_W-1:0]] <= fall_lanes;
        stk_pc_ff[sp_ff[`WIT_SP_W-1:0]] <= instr_pc_i + 16'h0001;
        stk_join_ff[sp_ff[`WIT_SP_W-1:0]] <= branch_join_i;
        stk_all_ff[sp_ff[`WIT_SP_W-1:0]] <= active_ff;
        stk_side_ff[sp_ff[`WIT_SP_W-1:0]] <= 1'b0;
      end
      if (pop_second) begin
        stk_side_ff[top] <= 1'b1;
      end
      // Outstanding global load: set wins over completion
      // A load with no true lane never reaches memory, so nothing is awaited
      if (accept && (instr_op_i == `WIT_OP_LDG) && (act_lanes != `WIT_MASK_ZERO)) begin
        load_wait_ff <= 1'b1; // RULE16
      end else if (mem_done_s2_ff) begin
        load_wait_ff <= 1'b0;
      end
      ldg_ff <= accept && is_global(instr_op_i);
    end
  end

  // Registered outputs: operand read, execute, writeback per lane
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_ready_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_lane_mask_o <= `WIT_MASK_ZERO;
      opnd_rd_o <= 1'b0;
      opnd_rd_mask_o <= `WIT_MASK_ZERO;
      exec_o <= 1'b0;
      wb_o <= 1'b0;
      wb_mask_o <= `WIT_MASK_ZERO;
      active_mask_o <= `WIT_MASK_ONES;
      next_pc_o <= 16'h0000;
      load_wait_o <= 1'b0;
      issue_op_o <= `WIT_OP_SIMPLE;
    end else begin
      // Ready rises on the last counted cycle, so the next offer is taken
      // at the edge after the one at which the current issue count has run out
      instr_ready_o <= (nxt_state == ST_IDLE) && !(accept || (cnt_busy && !cnt_last)); // RULE19
      opnd_rd_o <= accept; // RULE1
      opnd_rd_mask_o <= accept ? act_lanes : `WIT_MASK_ZERO; // RULE14
      exec_o <= opnd_rd_o; // RULE1
      wb_o <= exec_o && writes_back(op_ff); // RULE1
      wb_mask_o <= exec_o ? lane_ff : `WIT_MASK_ZERO; // RULE14
      mem_req_o <= ldg_ff && (lane_ff != `WIT_MASK_ZERO);
      mem_we_o <= ldg_ff && (op_ff == `WIT_OP_STG);
      mem_lane_mask_o <= ldg_ff ? lane_ff : `WIT_MASK_ZERO; // RULE14
      active_mask_o <= active_ff;
      next_pc_o <= pc_ff;
      load_wait_o <= load_wait_ff;
      issue_op_o <= op_ff;
    end
  end

endmodule

//--- wit_map.vh
// Opcode codes, issue cycle counts and widths for the warp issue timing block
`ifndef WIT_MAP_VH
`define WIT_MAP_VH

// Opcode classes
`define WIT_OP_W 4
`define WIT_OP_SIMPLE 4'h0
`define WIT_OP_RCP 4'h1
`define WIT_OP_MUL32 4'h2
`define WIT_OP_MUL24S 4'h3
`define WIT_OP_MUL24U 4'h4
`define WIT_OP_SQRT 4'h5
`define WIT_OP_DIV 4'h6
`define WIT_OP_FDIV 4'h7
`define WIT_OP_SFU 4'h8
`define WIT_OP_LDS 4'h9
`define WIT_OP_STS 4'ha
`define WIT_OP_LDG 4'hb
`define WIT_OP_STG 4'hc
`define WIT_OP_BAR 4'hd
`define WIT_OP_BRA 4'he

// Issue cycle counts
`define WIT_CNT_W 6
`define WIT_CYC_SIMPLE 6'h04
`define WIT_CYC_RCP 6'h10
`define WIT_CYC_MUL32 6'h10
`define WIT_CYC_SQRT 6'h20
`define WIT_CYC_DIV 6'h24
`define WIT_CYC_FDIV 6'h14
`define WIT_CYC_SFU 6'h20
`define WIT_CYC_MEM 6'h04
`define WIT_CYC_BAR 6'h04
`define WIT_CYC_ONE 6'h01

// Warp shape
`define WIT_LANES 32
`define WIT_WID_W 5
`define WIT_PC_W 16
`define WIT_DIV_DEPTH 4
`define WIT_SP_W 2
`define WIT_MASK_ONES 32'hffffffff
`define WIT_MASK_ZERO 32'h00000000

`endif

//--- wit_mem_model.sv
// Device memory model answering global loads
`timescale 1ns/1ps
module wit_mem_model #(
  parameter LAT_MIN = 400,
  parameter LAT_SPAN = 201
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Request and answer
  input wire mem_req_i,
  input wire mem_we_i,
  output reg mem_done_o
);
  integer wait_cyc;
  // Return a load after the memory latency, then drop the answer; requests made meanwhile are not seen
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mem_done_o <= 1'b0;
    end else if (mem_req_i && !mem_we_i) begin
      wait_cyc = LAT_MIN + ($urandom % LAT_SPAN);
      repeat (wait_cyc) @(posedge core_clk_i);
      mem_done_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      mem_done_o <= 1'b0;
    end
  end
endmodule
